//--- include/amf_pkg.sv
package amf_pkg;
    // Register byte addresses
    localparam logic [7:0] ADDR_RAW = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_MASK = 8'h08;
    localparam logic [7:0] ADDR_OVR = 8'h0c;
    localparam logic [7:0] ADDR_REG = 8'h10;
    // Implemented bit sets
    localparam logic [15:0] ALARM_USED = 16'hfec7;
    localparam logic [7:0] OVR_USED = 8'h0f;
    localparam logic [7:0] REGCTL_USED = 8'h1f;
    // Bit positions
    localparam int B_POR = 0;
    localparam int B_CD = 1;
    localparam int B_INIT = 2;
    localparam int B_CHK0 = 6;
    localparam int B_CHK1 = 7;
    localparam int B_SHUTDOWN_VOLTAGE_FLAG = 9;
    localparam int B_DISCHARGE_OFF_FLAG = 10;
    localparam int B_CHARGE_OFF_FLAG = 11;
    localparam int B_SAB = 12;
    localparam int B_SAA = 13;
    localparam int B_SSB = 14;
    localparam int B_SSA = 15;
    localparam int O_DISCHARGE_DRV_FORCE_ON = 0;
    localparam int O_CHARGE_DRV_FORCE_ON = 1;
    localparam int O_DISCHARGE_DRV_FORCE_OFF = 2;
    localparam int O_CHARGE_DRV_FORCE_OFF = 3;
    localparam int R_REG_EN = 3;
    localparam int R_THERMISTOR_BIAS_HOLD = 4;
    // Reset values
    localparam logic [7:0] OVR_RST = 8'h00;
    localparam logic [7:0] REGCTL_RST = 8'h00;
    localparam logic [31:0] BAD_ADDR_DATA = 32'h00000000;
endpackage

//--- src/amf_alarm_fet.sv
// The address map and the APB slave port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module amf_alarm_fet (
    input wire logic clk, // 200 MHz clock
    input wire logic srst, // Sync reset, active high
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB write
    input wire logic [7:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error
    input wire logic fault_group_a_flag, // Safety status A any
    input wire logic fault_group_b_flag, // Safety status B any
    input wire logic warning_group_a_flag, // Safety alert A any
    input wire logic warning_group_b_flag, // Safety alert B any
    input wire logic cell_below_shutdown, // Cell under shutdown level
    input wire logic stack_below_shutdown, // Stack under shutdown level
    input wire logic charger_detect_pin, // Comparator output, async
    input wire logic charger_detect_debounced, // Debounced detect, same clock
    input wire logic normal_mode, // Device in normal mode
    input wire logic check_tick, // Check interval pulse
    input wire logic startup_eval_done, // First evaluation done pulse
    input wire logic por_flag, // Full-reset flag of status word
    input wire logic [15:0] default_alarm_mask, // Data memory default mask
    input wire logic mask_load, // Pulse: reload default mask
    input wire logic host_force_off_allow, // Data memory permission
    input wire logic host_force_on_allow, // Data memory permission
    input wire logic charge_auto_en, // Normal charge enabling
    input wire logic discharge_auto_en, // Normal discharge enabling
    output logic charge_switch_driver, // Charge driver on
    output logic discharge_switch_driver, // Discharge driver on
    output logic charge_off_flag, // Charge driver disabled
    output logic discharge_off_flag, // Discharge driver disabled
    output logic thermistor_bias_hold, // Keep thermistor pull-up on
    output logic aux_ldo_enable, // Auxiliary regulator enable
    output logic [2:0] aux_ldo_voltage_sel, // Regulator voltage code
    output logic alert_out, // Attention pin drive value
    output logic alert_oe // Attention pin output enable
);
    logic [15:0] mask_reg;
    logic [15:0] status_reg;
    logic [7:0] ovr_reg;
    logic [7:0] regctl_reg;
    logic [15:0] raw;
    logic cd_meta_reg, cd_sync_reg;
    logic cd_prev_reg;
    logic cd_change;
    logic chk_pulse_reg;
    logic init_pulse_reg;
    logic wr_acc, rd_acc, addr_ok;
    logic [15:0] clr;
    logic [15:0] set_bits;
    logic chg_next, dsg_next;

    // Two-stage sync on the comparator pin
    always_ff @(posedge clk) begin
        if (srst) begin
            cd_meta_reg <= 1'b0;
            cd_sync_reg <= 1'b0;
        end else begin
            cd_meta_reg <= charger_detect_pin;
            cd_sync_reg <= cd_meta_reg;
        end
    end

    // Previous debounced detect value for change flag
    always_ff @(posedge clk) begin
        if (srst) begin
            cd_prev_reg <= 1'b0;
        end else begin
            cd_prev_reg <= charger_detect_debounced;
        end
    end
    assign cd_change = charger_detect_debounced ^ cd_prev_reg;

    // One-cycle pulses for check and startup events
    always_ff @(posedge clk) begin
        if (srst) begin
            chk_pulse_reg <= 1'b0;
            init_pulse_reg <= 1'b0;
        end else begin
            chk_pulse_reg <= check_tick & normal_mode;
            init_pulse_reg <= startup_eval_done;
        end
    end

    // Raw flags; reserved positions forced to zero
    always_comb begin
        raw = 16'h0000;
        raw[amf_pkg::B_SSA] = fault_group_a_flag;
        raw[amf_pkg::B_SSB] = fault_group_b_flag;
        raw[amf_pkg::B_SAA] = warning_group_a_flag;
        raw[amf_pkg::B_SAB] = warning_group_b_flag;
        raw[amf_pkg::B_CHARGE_OFF_FLAG] = ~charge_switch_driver;
        raw[amf_pkg::B_DISCHARGE_OFF_FLAG] = ~discharge_switch_driver;
        raw[amf_pkg::B_SHUTDOWN_VOLTAGE_FLAG] = cell_below_shutdown | stack_below_shutdown;
        raw[amf_pkg::B_CHK1] = chk_pulse_reg;
        raw[amf_pkg::B_CHK0] = chk_pulse_reg;
        raw[amf_pkg::B_INIT] = init_pulse_reg;
        raw[amf_pkg::B_CD] = cd_sync_reg;
        raw[amf_pkg::B_POR] = por_flag;
    end

    // APB decode: zero wait states
    assign pready = 1'b1;
    assign addr_ok = (paddr == amf_pkg::ADDR_RAW) || (paddr == amf_pkg::ADDR_STATUS) ||
                     (paddr == amf_pkg::ADDR_MASK) || (paddr == amf_pkg::ADDR_OVR) ||
                     (paddr == amf_pkg::ADDR_REG);
    assign pslverr = psel & penable & ~addr_ok;
    assign wr_acc = psel & penable & pwrite & addr_ok;
    assign rd_acc = psel & ~penable & ~pwrite;

    // Change flag uses its own source, not raw bit 1
    always_comb begin
        set_bits = raw & mask_reg;
        set_bits[amf_pkg::B_CD] = cd_change & mask_reg[amf_pkg::B_CD];
    end
    assign clr = (wr_acc && paddr == amf_pkg::ADDR_STATUS) ? pwdata[15:0] : 16'h0000;

    // Latched status; a new event wins over a same-cycle clear
    always_ff @(posedge clk) begin
        if (srst) begin
            status_reg <= 16'h0000;
        end else begin
            status_reg <= ((status_reg & ~clr) | set_bits) & amf_pkg::ALARM_USED;
        end
    end

    // Mask: cleared on reset, default on reload, host may rewrite
    always_ff @(posedge clk) begin
        if (srst) begin
            mask_reg <= 16'h0000;
        end else if (mask_load) begin
            mask_reg <= default_alarm_mask & amf_pkg::ALARM_USED;
        end else if (wr_acc && paddr == amf_pkg::ADDR_MASK) begin
            mask_reg <= pwdata[15:0] & amf_pkg::ALARM_USED;
        end
    end

    // Override and regulator control registers
    always_ff @(posedge clk) begin
        if (srst) begin
            ovr_reg <= amf_pkg::OVR_RST;
            regctl_reg <= amf_pkg::REGCTL_RST;
        end else if (wr_acc && paddr == amf_pkg::ADDR_OVR) begin
            ovr_reg <= pwdata[7:0] & amf_pkg::OVR_USED;
        end else if (wr_acc && paddr == amf_pkg::ADDR_REG) begin
            regctl_reg <= pwdata[7:0] & amf_pkg::REGCTL_USED;
        end
    end

    // Read data registered in setup phase, held through access
    always_ff @(posedge clk) begin
        if (srst) begin
            prdata <= amf_pkg::BAD_ADDR_DATA;
        end else if (rd_acc) begin
            unique case (paddr)
                amf_pkg::ADDR_RAW: prdata <= {16'h0000, raw};
                amf_pkg::ADDR_STATUS: prdata <= {16'h0000, status_reg};
                amf_pkg::ADDR_MASK: prdata <= {16'h0000, mask_reg};
                amf_pkg::ADDR_OVR: prdata <= {24'h000000, ovr_reg};
                amf_pkg::ADDR_REG: prdata <= {24'h000000, regctl_reg};
                default: prdata <= amf_pkg::BAD_ADDR_DATA;
            endcase
        end
    end

    // Driver resolution: force-off beats force-on beats normal enabling
    always_comb begin
        chg_next = charge_auto_en;
        dsg_next = discharge_auto_en;
        if (host_force_on_allow && ovr_reg[amf_pkg::O_CHARGE_DRV_FORCE_ON]) begin
            chg_next = 1'b1;
        end
        if (host_force_on_allow && ovr_reg[amf_pkg::O_DISCHARGE_DRV_FORCE_ON]) begin
            dsg_next = 1'b1;
        end
        if (host_force_off_allow && ovr_reg[amf_pkg::O_CHARGE_DRV_FORCE_OFF]) begin
            chg_next = 1'b0;
        end
        if (host_force_off_allow && ovr_reg[amf_pkg::O_DISCHARGE_DRV_FORCE_OFF]) begin
            dsg_next = 1'b0;
        end
    end

    // Registered driver outputs, off after reset
    always_ff @(posedge clk) begin
        if (srst) begin
            charge_switch_driver <= 1'b0;
            discharge_switch_driver <= 1'b0;
        end else begin
            charge_switch_driver <= chg_next;
            discharge_switch_driver <= dsg_next;
        end
    end
    assign charge_off_flag = ~charge_switch_driver;
    assign discharge_off_flag = ~discharge_switch_driver;

    // Regulator control fields
    assign thermistor_bias_hold = regctl_reg[amf_pkg::R_THERMISTOR_BIAS_HOLD];
    assign aux_ldo_enable = regctl_reg[amf_pkg::R_REG_EN];
    assign aux_ldo_voltage_sel = regctl_reg[2:0];

    // Open-drain attention: drive low only while something is latched
    assign alert_out = 1'b0;
    assign alert_oe = |status_reg;

    // Checks
    latch_hold_a: assert property (@(posedge clk) disable iff (srst)
        status_reg[amf_pkg::B_SHUTDOWN_VOLTAGE_FLAG] && !clr[amf_pkg::B_SHUTDOWN_VOLTAGE_FLAG] |=> status_reg[amf_pkg::B_SHUTDOWN_VOLTAGE_FLAG])
        else $error("latched bit lost without clear");
    shutdown_voltage_flag_clear_a: assert property (@(posedge clk) disable iff (srst)
        clr[amf_pkg::B_SHUTDOWN_VOLTAGE_FLAG] && !set_bits[amf_pkg::B_SHUTDOWN_VOLTAGE_FLAG] |=> !status_reg[amf_pkg::B_SHUTDOWN_VOLTAGE_FLAG])
        else $error("shutdown flag not cleared");
    mask_gate_a: assert property (@(posedge clk) disable iff (srst)
        !mask_reg[amf_pkg::B_DISCHARGE_OFF_FLAG] && !status_reg[amf_pkg::B_DISCHARGE_OFF_FLAG] |=> !status_reg[amf_pkg::B_DISCHARGE_OFF_FLAG])
        else $error("masked source latched");
    discharge_off_flag_raw_a: assert property (@(posedge clk) disable iff (srst)
        raw[amf_pkg::B_DISCHARGE_OFF_FLAG] == !discharge_switch_driver)
        else $error("raw discharge-off bit wrong");
    force_off_a: assert property (@(posedge clk) disable iff (srst)
        host_force_off_allow && ovr_reg[amf_pkg::O_CHARGE_DRV_FORCE_OFF] |=> !charge_switch_driver)
        else $error("charge driver not forced off");
    force_on_a: assert property (@(posedge clk) disable iff (srst)
        host_force_on_allow && ovr_reg[amf_pkg::O_DISCHARGE_DRV_FORCE_ON] && !(host_force_off_allow && ovr_reg[amf_pkg::O_DISCHARGE_DRV_FORCE_OFF])
        |=> discharge_switch_driver)
        else $error("discharge driver not forced on");
    on_gated_a: assert property (@(posedge clk) disable iff (srst)
        !host_force_on_allow && !charge_auto_en |=> !charge_switch_driver)
        else $error("force-on acted without permission");
    alert_pin_a: assert property (@(posedge clk) disable iff (srst)
        alert_oe == (status_reg != 16'h0000) && !alert_out)
        else $error("attention pin mismatch");
    cd_change_a: assert property (@(posedge clk) disable iff (srst)
        mask_reg[amf_pkg::B_CD] && (charger_detect_debounced != $past(charger_detect_debounced))
        |=> status_reg[amf_pkg::B_CD])
        else $error("detect change not latched");
    check_pulse_a: assert property (@(posedge clk) disable iff (srst)
        check_tick && normal_mode |=> raw[amf_pkg::B_CHK0] && raw[amf_pkg::B_CHK1] ##1 !raw[amf_pkg::B_CHK1] || check_tick)
        else $error("check pulse shape wrong");
    rsvd_zero_a: assert property (@(posedge clk) disable iff (srst)
        (mask_reg & ~amf_pkg::ALARM_USED) == 16'h0000 && (ovr_reg & ~amf_pkg::OVR_USED) == 8'h00)
        else $error("reserved bits set");

    // Raw flag sources, checked in the raw vector against the inputs rather than in the latched status
    raw_shutdown_voltage_flag_a: assert property (@(posedge clk) disable iff (srst)
        raw[amf_pkg::B_SHUTDOWN_VOLTAGE_FLAG] == (cell_below_shutdown | stack_below_shutdown))
        else $error("raw shutdown bit wrong");
    raw_por_a: assert property (@(posedge clk) disable iff (srst)
        raw[amf_pkg::B_POR] == por_flag)
        else $error("raw reset-flag bit wrong");
    // Detect pin reaches the raw bit two edges late through the synchroniser
    raw_detect_a: assert property (@(posedge clk) disable iff (srst)
        !$past(srst) && !$past(srst, 2) |-> raw[amf_pkg::B_CD] == $past(charger_detect_pin, 2))
        else $error("raw detect bit wrong");
    init_pulse_a: assert property (@(posedge clk) disable iff (srst)
        startup_eval_done |=> raw[amf_pkg::B_INIT])
        else $error("startup pulse missing");

    // Latching: an enabled source lands even against a same-cycle clear
    raw_latch_a: assert property (@(posedge clk) disable iff (srst)
        set_bits[amf_pkg::B_SHUTDOWN_VOLTAGE_FLAG] |=> status_reg[amf_pkg::B_SHUTDOWN_VOLTAGE_FLAG])
        else $error("enabled source not latched");
    shutdown_voltage_flag_alert_a: assert property (@(posedge clk) disable iff (srst)
        status_reg[amf_pkg::B_SHUTDOWN_VOLTAGE_FLAG] |-> alert_oe && !alert_out)
        else $error("shutdown flag without attention");
    mask_load_a: assert property (@(posedge clk) disable iff (srst)
        mask_load |=> mask_reg == ($past(default_alarm_mask) & amf_pkg::ALARM_USED))
        else $error("default mask not loaded");

    // Driver overrides; force-off wins, both need their permission
    discharge_drv_force_off_a: assert property (@(posedge clk) disable iff (srst)
        host_force_off_allow && ovr_reg[amf_pkg::O_DISCHARGE_DRV_FORCE_OFF] |=> !discharge_switch_driver)
        else $error("discharge driver not forced off");
    charge_drv_force_on_a: assert property (@(posedge clk) disable iff (srst)
        host_force_on_allow && ovr_reg[amf_pkg::O_CHARGE_DRV_FORCE_ON] && !(host_force_off_allow && ovr_reg[amf_pkg::O_CHARGE_DRV_FORCE_OFF])
        |=> charge_switch_driver)
        else $error("charge driver not forced on");
    off_gated_a: assert property (@(posedge clk) disable iff (srst)
        !host_force_off_allow && charge_auto_en |=> charge_switch_driver)
        else $error("force-off acted without permission");

    // Register writes land in the controls one edge later
    ts_hold_a: assert property (@(posedge clk) disable iff (srst)
        wr_acc && paddr == amf_pkg::ADDR_REG |=> thermistor_bias_hold == $past(pwdata[amf_pkg::R_THERMISTOR_BIAS_HOLD]))
        else $error("thermistor hold not written");
    ldo_en_a: assert property (@(posedge clk) disable iff (srst)
        wr_acc && paddr == amf_pkg::ADDR_REG |=> aux_ldo_enable == $past(pwdata[amf_pkg::R_REG_EN]))
        else $error("regulator enable not written");
    ovr_write_a: assert property (@(posedge clk) disable iff (srst)
        wr_acc && paddr == amf_pkg::ADDR_OVR |=> ovr_reg == ($past(pwdata[7:0]) & amf_pkg::OVR_USED))
        else $error("override write wrong");
    upper_zero_a: assert property (@(posedge clk) disable iff (srst)
        rd_acc |=> prdata[31:16] == 16'h0000)
        else $error("upper read bits not zero");

    cov_alert_c: cover property (@(posedge clk) disable iff (srst) !alert_oe ##1 alert_oe);
    cov_clear_c: cover property (@(posedge clk) disable iff (srst) alert_oe ##1 !alert_oe);
    cov_force_c: cover property (@(posedge clk) disable iff (srst)
        host_force_off_allow && ovr_reg[amf_pkg::O_CHARGE_DRV_FORCE_OFF] && charge_auto_en);
    cov_race_c: cover property (@(posedge clk) disable iff (srst) |(clr & set_bits));
    cov_change_c: cover property (@(posedge clk) disable iff (srst) cd_change && mask_reg[amf_pkg::B_CD]);
endmodule
`default_nettype wire

//--- test/amf_host_model.sv
`timescale 1ns/10ps
`default_nettype none
// Host controller on the register bus, one transfer at a time
module amf_host_model (
    input wire logic clk, // Bus clock
    output logic psel, // Select
    output logic penable, // Access phase
    output logic pwrite, // Direction
    output logic [7:0] paddr, // Byte address
    output logic [31:0] pwdata, // Write data
    input wire logic [31:0] prdata, // Read data
    input wire logic pready, // Ready
    input wire logic pslverr // Error
);
    // Idle bus from time zero
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h00000000;
    end
    // Request held until pready is seen; the bench timeout ends a hang
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule
`default_nettype wire

//--- test/alarm_mask_and_fet_override_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, x) begin num_checks++; if ((a) !== (x)) begin err_total++; \
    $display("unexpected t=%0t got=%h exp=%h", $time, (a), (x)); end end
module alarm_mask_and_fet_override_tb_top;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic psel, penable, pwrite, pready, pslverr, e, alert_out, alert_oe;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic fault_group_a_flag = 0, fault_group_b_flag = 0, warning_group_a_flag = 0, warning_group_b_flag = 0;
    logic cell_below_shutdown = 0, stack_below_shutdown = 0, charger_detect_pin = 0, charger_detect_debounced = 0;
    logic normal_mode = 0, check_tick = 0, startup_eval_done = 0, por_flag = 0, mask_load = 0;
    logic [15:0] default_alarm_mask = 16'h0000;
    logic host_force_off_allow = 0, host_force_on_allow = 0, charge_auto_en = 0, discharge_auto_en = 0;
    logic charge_switch_driver, discharge_switch_driver, charge_off_flag, discharge_off_flag;
    logic thermistor_bias_hold, aux_ldo_enable;
    logic [2:0] aux_ldo_voltage_sel;
    int err_total = 0;
    int num_checks = 0;
    int cyc = 0;
    // 200 MHz clock
    always #2.5 clk = ~clk;
    amf_alarm_fet amf_alarm_fet_inst (.clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .fault_group_a_flag, .fault_group_b_flag, .warning_group_a_flag,
        .warning_group_b_flag, .cell_below_shutdown, .stack_below_shutdown, .charger_detect_pin,
        .charger_detect_debounced, .normal_mode, .check_tick, .startup_eval_done, .por_flag,
        .default_alarm_mask, .mask_load, .host_force_off_allow, .host_force_on_allow, .charge_auto_en,
        .discharge_auto_en, .charge_switch_driver, .discharge_switch_driver, .charge_off_flag,
        .discharge_off_flag, .thermistor_bias_hold, .aux_ldo_enable, .aux_ldo_voltage_sel, .alert_out,
        .alert_oe);
    amf_host_model amf_host_model_inst (.clk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr);
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        amf_host_model_inst.xfer(1'b1, a, d, q, e);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        amf_host_model_inst.xfer(1'b0, a, 32'h00000000, q, e);
        `CHK(q, x)
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic summarize();
        $display("checks=%0d mismatches=%0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // Whole run needs about 140 cycles; cut a hang well after that
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            err_total++;
            summarize();
        end
    end
    // Main sequence
    initial begin
        idle(2);
        srst <= 1'b0;
        rd(amf_pkg::ADDR_OVR, 32'h00000000);
        rd(amf_pkg::ADDR_REG, 32'h00000000);
        rd(amf_pkg::ADDR_STATUS, 32'h00000000);
        rd(amf_pkg::ADDR_RAW, 32'h00000c00);
        `CHK(alert_oe, 1'b0)
        amf_host_model_inst.xfer(1'b0, 8'h20, 32'h00000000, q, e);
        `CHK({e, q}, 33'h100000000)
        $display("test reset done");
        default_alarm_mask <= 16'hffff;
        mask_load <= 1'b1;
        idle(1);
        mask_load <= 1'b0;
        rd(amf_pkg::ADDR_MASK, 32'h0000fec7);
        rd(amf_pkg::ADDR_STATUS, 32'h00000c00);
        `CHK({alert_oe, alert_out}, 2'b10)
        {fault_group_a_flag, fault_group_b_flag, warning_group_a_flag, warning_group_b_flag} <= 4'hf;
        {cell_below_shutdown, por_flag} <= 2'b11;
        idle(2);
        rd(amf_pkg::ADDR_RAW, 32'h0000fe01);
        {cell_below_shutdown, stack_below_shutdown} <= 2'b01;
        idle(2);
        rd(amf_pkg::ADDR_RAW, 32'h0000fe01);
        {fault_group_a_flag, fault_group_b_flag, warning_group_a_flag, warning_group_b_flag} <= 4'h0;
        {stack_below_shutdown, por_flag} <= 2'b00;
        idle(2);
        rd(amf_pkg::ADDR_STATUS, 32'h0000fe01);
        wr(amf_pkg::ADDR_STATUS, 32'h00000201);
        rd(amf_pkg::ADDR_STATUS, 32'h0000fc00);
        $display("test alarm latch done");
        host_force_on_allow <= 1'b1;
        wr(amf_pkg::ADDR_OVR, 32'h00000003);
        idle(2);
        `CHK({charge_switch_driver, discharge_switch_driver, charge_off_flag, discharge_off_flag}, 4'hc)
        wr(amf_pkg::ADDR_STATUS, 32'h0000ffff);
        rd(amf_pkg::ADDR_STATUS, 32'h00000000);
        `CHK(alert_oe, 1'b0)
        wr(amf_pkg::ADDR_OVR, 32'h000000ff);
        rd(amf_pkg::ADDR_OVR, 32'h0000000f);
        `CHK({charge_switch_driver, discharge_switch_driver}, 2'b11)
        host_force_off_allow <= 1'b1;
        wr(amf_pkg::ADDR_OVR, 32'h0000000b);
        idle(2);
        `CHK({charge_switch_driver, discharge_switch_driver}, 2'b01)
        wr(amf_pkg::ADDR_OVR, 32'h00000007);
        idle(2);
        `CHK({charge_switch_driver, discharge_switch_driver}, 2'b10)
        host_force_on_allow <= 1'b0;
        wr(amf_pkg::ADDR_OVR, 32'h00000003);
        idle(2);
        `CHK({charge_switch_driver, discharge_switch_driver}, 2'b00)
        rd(amf_pkg::ADDR_STATUS, 32'h00000c00);
        {charge_auto_en, discharge_auto_en} <= 2'b11;
        idle(2);
        `CHK({charge_switch_driver, discharge_switch_driver}, 2'b11)
        wr(amf_pkg::ADDR_OVR, 32'h0000000c);
        idle(2);
        `CHK({charge_switch_driver, discharge_switch_driver}, 2'b00)
        wr(amf_pkg::ADDR_REG, 32'h000000ff);
        rd(amf_pkg::ADDR_REG, 32'h0000001f);
        `CHK({thermistor_bias_hold, aux_ldo_enable, aux_ldo_voltage_sel}, 5'h1f)
        wr(amf_pkg::ADDR_REG, 32'h00000008);
        idle(1);
        `CHK({thermistor_bias_hold, aux_ldo_enable}, 2'b01)
        $display("test override done");
        // Bit 0 masked out while the reset flag is up
        wr(amf_pkg::ADDR_MASK, 32'h000000c6);
        wr(amf_pkg::ADDR_STATUS, 32'h0000ffff);
        por_flag <= 1'b1;
        check_tick <= 1'b1;
        idle(1);
        check_tick <= 1'b0;
        idle(3);
        rd(amf_pkg::ADDR_STATUS, 32'h00000000);
        normal_mode <= 1'b1;
        check_tick <= 1'b1;
        idle(1);
        check_tick <= 1'b0;
        idle(3);
        rd(amf_pkg::ADDR_STATUS, 32'h000000c0);
        startup_eval_done <= 1'b1;
        idle(1);
        startup_eval_done <= 1'b0;
        idle(3);
        rd(amf_pkg::ADDR_STATUS, 32'h000000c4);
        charger_detect_debounced <= 1'b1;
        idle(3);
        rd(amf_pkg::ADDR_STATUS, 32'h000000c6);
        charger_detect_pin <= 1'b1;
        idle(4);
        rd(amf_pkg::ADDR_RAW, 32'h00000c03);
        $display("test events done");
        summarize();
    end
endmodule
`default_nettype wire
